// [src/phy_ctl_pkg.sv]
package phy_ctl_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] pwr_sig_addr  = 12'h03c;
  localparam logic [11:0] phy_ctl_addr  = 12'h040;
  localparam logic [11:0] irq_stat_addr = 12'h044;
  localparam logic [11:0] irq_mask_addr = 12'h048;
  localparam logic [11:0] line_st_addr  = 12'h04c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int pwr_data_lsb  = 0;
  localparam int pwr_data_msb  = 7;
  localparam int pwr_valid_bit = 8;
  localparam int pd_dis_bit    = 18;
  localparam int se0_flag_bit  = 13;
  localparam int k_flag_bit    = 12;
  localparam int filt_lsb      = 8;
  localparam int filt_msb      = 11;
  localparam int auto_res_bit  = 7;
  localparam int conf_lsb      = 4;
  localparam int conf_msb      = 6;

  // Interrupt status bits: 0 resume by SE0, 1 resume by K, 2 line change
  localparam int irq_se0_bit  = 0;
  localparam int irq_k_bit    = 1;
  localparam int irq_line_bit = 2;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] pwr_sig_rst  = 32'h0000_0000;
  localparam logic [31:0] phy_ctl_rst  = 32'h0000_0000;
  localparam logic [2:0]  irq_rst      = 3'h0;
  localparam logic [1:0]  line_se0     = 2'h0;
  localparam logic [1:0]  line_j       = 2'h1;
  localparam logic [1:0]  line_k       = 2'h2;
  localparam int          cnt_w        = 16;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic        pd_off;
    logic [2:0]  conf;
  } phy_pins_t;

endpackage

// [src/line_filter.sv]
`timescale 1ns/1ps
module line_filter
  import phy_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [3:0] depth_log2,
  // Line state
  input  wire logic [1:0] line_raw,
  output logic      [1:0] line_filt,
  output logic            changed
);

  typedef struct packed {
    logic [1:0]       cand;
    logic [cnt_w-1:0] cnt;
    logic [1:0]       filt;
    logic             chg;
  } filt_st_t;

  filt_st_t st_r;
  filt_st_t st_nxt;

  function automatic logic [cnt_w-1:0] pow2(input logic [3:0] e);
    pow2 = cnt_w'(1) << e;
  endfunction

  // -------------------------------------------------------------
  // Stability counter
  // -------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.chg = 1'b0;
    if (line_raw != st_r.cand) begin
      st_nxt.cand = line_raw;
      st_nxt.cnt  = cnt_w'(1);
    end else if (st_r.cand != st_r.filt) begin
      if (st_r.cnt >= pow2(depth_log2)) begin
        st_nxt.filt = st_r.cand;
        st_nxt.chg  = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + cnt_w'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{cand: line_j, cnt: '0, filt: line_j, chg: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign line_filt = st_r.filt;
  assign changed   = st_r.chg;

  a_filt_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.chg |-> $past(line_raw) == st_r.filt)
    else $error("filter passed an unstable value");

endmodule // line_filter

// [src/apb_slave.sv]
`timescale 1ns/1ps
module apb_slave
  import phy_ctl_pkg::*;
(
  // Bus
  input  wire apb_req_t req,
  input  wire logic [31:0] rd_word,
  output logic      wr_stb,
  output logic      rd_stb,
  output logic      pready,
  output logic      pslverr,
  output logic [31:0] prdata
);

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == pwr_sig_addr) || (a == phy_ctl_addr) ||
             (a == irq_stat_addr) || (a == irq_mask_addr) ||
             (a == line_st_addr);
  endfunction

  // Zero wait states; unmapped addresses give pslverr
  always_comb begin
    pready  = req.psel & req.penable;
    pslverr = pready & ~mapped(req.paddr);
    wr_stb  = pready & req.pwrite & mapped(req.paddr);
    rd_stb  = pready & ~req.pwrite & mapped(req.paddr);
    prdata  = pready & ~req.pwrite ? rd_word : 32'h0000_0000;
  end

endmodule // apb_slave

// [src/phy_suspend_ctl.sv]
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module phy_suspend_ctl
  import phy_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Suspend
  input  wire logic        suspended,
  output logic             resume_req,
  // Transceiver
  input  wire logic [1:0]  line_state,
  output logic      [2:0]  transceiver_config_pins,
  output logic             wide_port_a_pd_en,
  output logic             wide_port_b_pd_en,
  // Power signalling
  output logic      [7:0]  pwr_data,
  output logic             pwr_valid,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic [1:0]  ls_s1;
    logic [1:0]  ls_s2;
    logic        sus_s1;
    logic        sus_s2;
    logic [8:0]  pwr;
    logic        pd_off;
    logic        se0_flag;
    logic        k_flag;
    logic [3:0]  depth;
    logic        auto_res;
    logic [2:0]  conf;
    logic        res_req;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } ctl_st_t;

  ctl_st_t     st_r;
  ctl_st_t     st_nxt;
  apb_req_t    req;
  logic        wr_stb;
  logic        rd_stb;
  logic        wr_hit;
  logic        rd_hit;
  logic        auto_hit;
  logic        bus_ready;
  logic        bus_err;
  logic [31:0] bus_rdata;
  logic [31:0] rd_word;
  logic [1:0]  line_filt;
  logic        line_chg;

  // ---------------------------------------------------------------
  // Bus slave and filter
  // ---------------------------------------------------------------
  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  apb_slave u_bus (
    .req     (req),
    .rd_word (rd_word),
    .wr_stb  (wr_hit),
    .rd_stb  (rd_hit),
    .pready  (bus_ready),
    .pslverr (bus_err),
    .prdata  (bus_rdata)
  );

  // Accesses act only at the edge that sees pready high
  assign wr_stb   = wr_hit & st_r.ready;
  assign rd_stb   = rd_hit & st_r.ready;
  assign auto_hit = st_r.auto_res & st_r.sus_s2 & line_chg;

  line_filter u_filt (
    .pclk       (pclk),
    .presetn    (presetn),
    .depth_log2 (st_r.depth),
    .line_raw   (st_r.ls_s2),
    .line_filt  (line_filt),
    .changed    (line_chg)
  );

  function automatic logic [31:0] ctl_word(input ctl_st_t s);
    ctl_word = 32'h0000_0000;
    ctl_word[pd_dis_bit]        = s.pd_off;
    ctl_word[se0_flag_bit]      = s.se0_flag;
    ctl_word[k_flag_bit]        = s.k_flag;
    ctl_word[filt_msb:filt_lsb] = s.depth;
    ctl_word[auto_res_bit]      = s.auto_res;
    ctl_word[conf_msb:conf_lsb] = s.conf;
  endfunction

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      pwr_sig_addr:  rd_word = {23'h000000, st_r.pwr};
      phy_ctl_addr:  rd_word = ctl_word(st_r);
      irq_stat_addr: rd_word = {29'h00000000, st_r.irq_stat};
      irq_mask_addr: rd_word = {29'h00000000, st_r.irq_mask};
      line_st_addr:  rd_word = {30'h00000000, line_filt};
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic res_se0;
    logic res_k;
    res_se0 = 1'b0;
    res_k   = 1'b0;
    st_nxt  = st_r;
    st_nxt.ls_s1  = line_state;
    st_nxt.ls_s2  = st_r.ls_s1;
    st_nxt.sus_s1 = suspended;
    st_nxt.sus_s2 = st_r.sus_s1;
    st_nxt.rdata  = bus_rdata;
    // One-cycle pready pulse, a fresh answer for each access
    st_nxt.ready  = bus_ready & ~st_r.ready;
    st_nxt.slverr = bus_err & ~st_r.ready;
    st_nxt.res_req = 1'b0;
    // Register writes
    if (wr_stb && paddr == pwr_sig_addr) begin
      st_nxt.pwr = pwdata[pwr_valid_bit:pwr_data_lsb];
    end
    if (wr_stb && paddr == phy_ctl_addr) begin
      st_nxt.pd_off   = pwdata[pd_dis_bit];
      st_nxt.depth    = pwdata[filt_msb:filt_lsb];
      st_nxt.auto_res = pwdata[auto_res_bit];
      st_nxt.conf     = pwdata[conf_msb:conf_lsb];
      if (!pwdata[se0_flag_bit]) st_nxt.se0_flag = 1'b0;
      if (!pwdata[k_flag_bit])   st_nxt.k_flag = 1'b0;
    end
    if (wr_stb && paddr == irq_mask_addr) begin
      st_nxt.irq_mask = pwdata[2:0];
    end
    // Clear only the bits handed over, so newer events survive
    if (rd_stb && paddr == irq_stat_addr) begin
      st_nxt.irq_stat = st_r.irq_stat & ~st_r.rdata[2:0];
    end
    // Hardware resume on filtered activity; set wins over clear
    if (auto_hit) begin
      if (line_filt == line_se0) res_se0 = 1'b1;
      if (line_filt == line_k)   res_k = 1'b1;
    end
    if (res_se0) begin
      st_nxt.se0_flag = 1'b1;
      st_nxt.irq_stat[irq_se0_bit] = 1'b1;
    end
    if (res_k) begin
      st_nxt.k_flag = 1'b1;
      st_nxt.irq_stat[irq_k_bit] = 1'b1;
    end
    if (line_chg) st_nxt.irq_stat[irq_line_bit] = 1'b1;
    st_nxt.res_req = res_se0 | res_k;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.ls_s1    <= line_j;
      st_r.ls_s2    <= line_j;
      st_r.pwr      <= pwr_sig_rst[8:0];
      st_r.pd_off   <= phy_ctl_rst[pd_dis_bit];
      st_r.conf     <= phy_ctl_rst[conf_msb:conf_lsb];
      st_r.irq_stat <= irq_rst;
      st_r.irq_mask <= irq_rst;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Bus answer is registered: one wait state, pready one cycle late
  assign prdata  = st_r.rdata;
  assign pready  = st_r.ready;
  assign pslverr = st_r.slverr;
  assign resume_req              = st_r.res_req;
  assign transceiver_config_pins = st_r.conf;
  assign wide_port_a_pd_en       = ~st_r.pd_off;
  assign wide_port_b_pd_en       = ~st_r.pd_off;
  assign pwr_data                = st_r.pwr[7:0];
  assign pwr_valid               = st_r.pwr[8];
  assign irq                     = st_r.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pd_follow: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == phy_ctl_addr) |=>
      wide_port_a_pd_en == !$past(pwdata[pd_dis_bit]))
    else $error("pulldown enable does not follow control bit");

  a_pd_both: assert property (@(posedge pclk)
    disable iff (!presetn)
    wide_port_a_pd_en == wide_port_b_pd_en)
    else $error("wide port pulldown enables differ");

  a_conf_pins: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == phy_ctl_addr) |=>
      transceiver_config_pins == $past(pwdata[conf_msb:conf_lsb]))
    else $error("config pins do not follow control bits");

  a_pwr_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == pwr_sig_addr) |=>
      {pwr_valid, pwr_data} == $past(pwdata[pwr_valid_bit:pwr_data_lsb]))
    else $error("power signalling register not written");

  a_pwr_reserved: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_stb && paddr == pwr_sig_addr) |->
      prdata[31:pwr_valid_bit+1] == '0)
    else $error("reserved power signalling bits read non-zero");

  a_se0_sticky: assert property (@(posedge pclk)
    disable iff (!presetn)
    (st_r.se0_flag && !(wr_stb && paddr == phy_ctl_addr)) |=>
      st_r.se0_flag)
    else $error("se0 resume flag lost without a write");

  a_k_sticky: assert property (@(posedge pclk)
    disable iff (!presetn)
    (st_r.k_flag && !(wr_stb && paddr == phy_ctl_addr)) |=>
      st_r.k_flag)
    else $error("k resume flag lost without a write");

  a_se0_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    (auto_hit && line_filt == line_se0) |=>
      (st_r.se0_flag && resume_req))
    else $error("se0 resume did not set its flag");

  a_k_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    (auto_hit && line_filt == line_k) |=>
      (st_r.k_flag && resume_req))
    else $error("k resume did not set its flag");

  a_se0_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == phy_ctl_addr && !pwdata[se0_flag_bit] &&
      !auto_hit) |=> !st_r.se0_flag)
    else $error("se0 resume flag not cleared by a zero write");

  a_k_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == phy_ctl_addr && !pwdata[k_flag_bit] &&
      !auto_hit) |=> !st_r.k_flag)
    else $error("k resume flag not cleared by a zero write");

  a_depth_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == phy_ctl_addr) |=>
      st_r.depth == $past(pwdata[filt_msb:filt_lsb]))
    else $error("filter depth field not written");

  a_auto_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_stb && paddr == phy_ctl_addr) |=>
      st_r.auto_res == $past(pwdata[auto_res_bit]))
    else $error("hardware resume enable not written");

  a_no_auto: assert property (@(posedge pclk)
    disable iff (!presetn)
    !st_r.auto_res |=> !resume_req)
    else $error("resume raised while hardware resume disabled");

  a_no_suspend: assert property (@(posedge pclk)
    disable iff (!presetn)
    !st_r.sus_s2 |=> !resume_req)
    else $error("resume raised outside suspend");

  a_res_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    resume_req |-> (st_r.se0_flag || st_r.k_flag))
    else $error("resume without a cause flag");

  a_res_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    resume_req |=> !resume_req)
    else $error("resume request longer than one cycle");

  a_line_read: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_stb && paddr == line_st_addr) |->
      prdata == {30'h00000000, $past(line_filt)})
    else $error("filtered line state read back wrong");

  a_line_irq: assert property (@(posedge pclk)
    disable iff (!presetn)
    line_chg |=> st_r.irq_stat[irq_line_bit])
    else $error("line change did not set its status bit");

  a_irq_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    irq == |(st_r.irq_stat & st_r.irq_mask))
    else $error("interrupt level mismatch");

  a_ready_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_err_ready: assert property (@(posedge pclk)
    disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  c_auto_se0: cover property (@(posedge pclk) resume_req && st_r.se0_flag);
  c_auto_k:   cover property (@(posedge pclk) resume_req && st_r.k_flag);
  c_irq:      cover property (@(posedge pclk) irq);
  c_err:      cover property (@(posedge pclk) pslverr);
  c_flag_clear: cover property (@(posedge pclk)
    wr_stb && paddr == phy_ctl_addr && st_r.k_flag && !pwdata[k_flag_bit]);

endmodule // phy_suspend_ctl

// [tb/phy_model.sv]
`timescale 1ns/1ps
module phy_model
  import phy_ctl_pkg::*;
(
  // Clock
  input  wire logic       pclk,
  // Configuration from the block
  input  wire logic [2:0] transceiver_config_pins,
  input  wire logic       wide_port_a_pd_en,
  input  wire logic       wide_port_b_pd_en,
  // Line state to the block
  output logic      [1:0] line_state
);
  logic [1:0] line_r = line_j;

  // Transceiver always drives its line state, idle is J
  assign line_state = line_r;

  task automatic set_line(input logic [1:0] v);
    @(posedge pclk);
    line_r <= v;
  endtask
endmodule // phy_model

// [tb/usb_phy_suspend_control_test.sv]
`timescale 1ns/1ps
module usb_phy_suspend_control_test;
  import phy_ctl_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        suspended = 1'b0;
  logic        resume_req;
  logic [1:0]  line_state;
  logic [2:0]  conf;
  logic        pd_a;
  logic        pd_b;
  logic [7:0]  pwr_data;
  logic        pwr_valid;
  logic        irq;
  logic        slv_err;
  logic [31:0] q;
  int          errors = 0;
  int          check_count = 0;
  int          res_cnt = 0;

  // ------------------------------------------------------------
  // Clock, reset, instances
  // ------------------------------------------------------------
  initial begin
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (resume_req === 1'b1) res_cnt <= res_cnt + 1;
  end

  phy_suspend_ctl u_phy_suspend_ctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .suspended(suspended),
    .resume_req(resume_req), .line_state(line_state),
    .transceiver_config_pins(conf), .wide_port_a_pd_en(pd_a),
    .wide_port_b_pd_en(pd_b), .pwr_data(pwr_data),
    .pwr_valid(pwr_valid), .irq(irq));

  phy_model u_phy_model (
    .pclk(pclk), .transceiver_config_pins(conf),
    .wide_port_a_pd_en(pd_a), .wide_port_b_pd_en(pd_b),
    .line_state(line_state));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_resume(input int n0);
    for (int i = 0; i < 40 && res_cnt == n0; i++) @(posedge pclk);
    tick(3);
  endtask

  task automatic wrap_up();
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, pwr_sig_addr, 32'h0);   check(q, 32'h0);
    apb(1'b0, phy_ctl_addr, 32'h0);   check(q, 32'h0);
    check({pd_a, pd_b}, 32'h3);
    check(conf, 32'h0);
    apb(1'b0, 12'h100, 32'h0);        check(slv_err, 32'h1);
  endtask

  task automatic t_regs();
    apb(1'b1, pwr_sig_addr, 32'hffff_ffff);
    apb(1'b0, pwr_sig_addr, 32'h0);   check(q, 32'h0000_01ff);
    check({pwr_valid, pwr_data}, 32'h1ff);
    apb(1'b1, pwr_sig_addr, 32'h0000_00a5);
    tick(1);
    check({pwr_valid, pwr_data}, 32'h0a5);
    apb(1'b1, phy_ctl_addr, 32'h0004_0050);
    tick(1);
    check({pd_a, pd_b}, 32'h0);
    check(conf, 32'h5);
    apb(1'b1, phy_ctl_addr, 32'hffff_ff7f);
    apb(1'b0, phy_ctl_addr, 32'h0);   check(q, 32'h0004_0f70);
    apb(1'b1, phy_ctl_addr, 32'h0);
    tick(1);
    check({pd_a, pd_b}, 32'h3);
  endtask

  task automatic t_filter();
    apb(1'b1, phy_ctl_addr, 32'h0000_0300);
    apb(1'b0, irq_stat_addr, 32'h0);
    u_phy_model.set_line(line_k);
    tick(3);
    u_phy_model.set_line(line_j);
    tick(12);
    apb(1'b0, line_st_addr, 32'h0);   check(q, 32'h1);
    apb(1'b0, irq_stat_addr, 32'h0);  check(q[2], 32'h0);
    u_phy_model.set_line(line_k);
    apb(1'b0, line_st_addr, 32'h0);
    apb(1'b0, line_st_addr, 32'h0);   check(q, 32'h1);
    q = 32'h0;
    for (int i = 0; i < 20 && q != 32'h2; i++) begin
      apb(1'b0, line_st_addr, 32'h0);
    end
    check(q, 32'h2);
    apb(1'b0, irq_stat_addr, 32'h0);  check(q[2], 32'h1);
    u_phy_model.set_line(line_j);
    suspended <= 1'b1;
    tick(20);
    apb(1'b1, phy_ctl_addr, 32'h0);
    u_phy_model.set_line(line_k);
    tick(20);
    check(res_cnt, 32'h0);
    u_phy_model.set_line(line_j);
    tick(10);
  endtask

  task automatic t_resume();
    logic irq_a;
    apb(1'b1, irq_mask_addr, 32'h0);
    apb(1'b1, phy_ctl_addr, 32'h0000_0080);
    apb(1'b0, irq_stat_addr, 32'h0);
    u_phy_model.set_line(line_k);
    wait_resume(0);
    check(res_cnt, 32'h1);
    apb(1'b0, phy_ctl_addr, 32'h0);   check(q, 32'h0000_1080);
    irq_a = irq;
    apb(1'b1, irq_mask_addr, 32'h7);
    tick(2);
    check(irq_a ^ irq, 32'h1);
    apb(1'b0, irq_stat_addr, 32'h0);  check(q[1:0], 32'h2);
    apb(1'b0, irq_stat_addr, 32'h0);  check(q, 32'h0);
    tick(2);
    check(irq, 32'h0);
    apb(1'b1, phy_ctl_addr, 32'h0000_0080);
    apb(1'b0, phy_ctl_addr, 32'h0);   check(q, 32'h0000_0080);
    u_phy_model.set_line(line_j);
    tick(10);
    u_phy_model.set_line(line_se0);
    wait_resume(res_cnt);
    apb(1'b0, phy_ctl_addr, 32'h0);   check(q, 32'h0000_2080);
    apb(1'b1, phy_ctl_addr, 32'h0000_0080);
    apb(1'b0, phy_ctl_addr, 32'h0);   check(q, 32'h0000_0080);
    check(res_cnt, 32'h2);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_filter();
    t_resume();
    wrap_up();
  end

  initial begin
    #40000;
    errors++;
    wrap_up();
  end
endmodule // usb_phy_suspend_control_test
